/* File: design/tw_pkg.sv */
// shared constants and state types of the two-wire bus unit
package tw_pkg;
  // ==========================================
  // clock and bus timing
  localparam int clk_hz = 250_000_000;
  localparam int scl_low_phase_count = 6;
  localparam int scl_high_phase_count = 4;
  localparam int std_rate_bps = 100_000;
  localparam int fast_rate_bps = 400_000;
  localparam int ticks_per_period = 2 * (scl_low_phase_count + scl_high_phase_count);
  // suggested divider values
  // rounded up so the bus never runs above the named rate
  localparam logic [7:0] std_rate_divider =
    8'((clk_hz + ticks_per_period * std_rate_bps - 1) / (ticks_per_period * std_rate_bps) - 1);
  localparam logic [7:0] fast_rate_divider =
    8'((clk_hz + ticks_per_period * fast_rate_bps - 1) / (ticks_per_period * fast_rate_bps) - 1);
  // one tick is (divider + 1) system clocks
  localparam logic [4:0] low_mid = 5'(scl_low_phase_count);
  localparam logic [4:0] low_last = 5'(2 * scl_low_phase_count - 1);
  localparam logic [4:0] high_last = 5'(2 * scl_high_phase_count - 1);
  localparam logic [3:0] ack_bit = 4'h8;
  localparam logic [3:0] after_ack = 4'h9;

  // ==========================================
  // reset values
  localparam logic [1:0] line_released = 2'h3;
  localparam logic [7:0] byte_reset = 8'h00;

  // ==========================================
  // state types
  typedef enum logic [2:0] {
    m_idle = 3'h0,
    m_start = 3'h1,
    m_bits = 3'h3,
    m_wait = 3'h2,
    m_stop = 3'h6,
    m_rstart = 3'h7
  } tw_mstate_type;

  typedef enum logic [1:0] {
    s_idle = 2'h0,
    s_addr = 2'h1,
    s_rx = 2'h3,
    s_tx = 2'h2
  } tw_sstate_type;
endpackage

/* File: design/tw_sync.sv */
// two-flop synchroniser for the sensed bus lines
`timescale 1ns/100ps
module tw_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] din,
  output logic [1:0] dout
);
  logic [1:0] meta;
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta[i] <= tw_pkg::line_released[i];
          dout[i] <= tw_pkg::line_released[i];
        end else begin
          meta[i] <= din[i];
          dout[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule

/* File: design/tw_slave.sv */
// slave function: address match, receive, transmit with clock stretch
`timescale 1ns/100ps
module tw_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic sda,
  input wire logic scl_rise,
  input wire logic scl_fall,
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic enable,
  input wire logic [6:0] own_address,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] rx_data,
  output logic rx_event,
  output logic tx_request
);
  tw_pkg::tw_sstate_type st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, next_rx_data;
  logic next_scl_low, next_sda_low, next_rx_event, next_tx_request;

  assign tx_ready = scl_low;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_rx_data = rx_data;
    next_rx_event = 1'b0;
    next_tx_request = 1'b0;
    if (start_det) begin
      next_st = tw_pkg::s_addr;
      next_cnt = 4'h0;
      next_sda_low = 1'b0;
      next_scl_low = 1'b0;
    end else if (stop_det || !enable) begin
      next_st = tw_pkg::s_idle;
      next_sda_low = 1'b0;
      next_scl_low = 1'b0;
    end else if (st != tw_pkg::s_idle) begin
      if (scl_low) begin
        // clock held low until data is supplied
        if (tx_valid) begin
          next_sh = tx_data;
          next_sda_low = !tx_data[7];
          next_scl_low = 1'b0;
        end
      end else if (scl_rise) begin
        if (cnt < tw_pkg::ack_bit) begin
          next_sh = {sh[6:0], sda};
        end else if (st == tw_pkg::s_tx && sda) begin
          // master declined, let go of the bus
          next_st = tw_pkg::s_idle;
        end
        next_cnt = cnt + 4'h1;
      end else if (scl_fall) begin
        if (cnt == tw_pkg::ack_bit) begin
          case (st)
            // stay released on a foreign address
            tw_pkg::s_addr: begin
              if (sh[7:1] == own_address) begin
                next_sda_low = 1'b1;
              end else begin
                next_st = tw_pkg::s_idle;
              end
            end
            tw_pkg::s_rx: begin
              next_sda_low = 1'b1;
              next_rx_data = sh;
              next_rx_event = 1'b1;
            end
            default: begin
              next_sda_low = 1'b0;
            end
          endcase
        end else if (cnt == tw_pkg::after_ack) begin
          next_sda_low = 1'b0;
          next_cnt = 4'h0;
          if (st == tw_pkg::s_tx || (st == tw_pkg::s_addr && sh[0])) begin
            next_st = tw_pkg::s_tx;
            next_scl_low = 1'b1;
            next_tx_request = 1'b1;
          end else begin
            next_st = tw_pkg::s_rx;
          end
        end else if (st == tw_pkg::s_tx) begin
          next_sda_low = !sh[7];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= tw_pkg::s_idle;
      cnt <= 4'h0;
      sh <= tw_pkg::byte_reset;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rx_data <= tw_pkg::byte_reset;
      rx_event <= 1'b0;
      tx_request <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      rx_data <= next_rx_data;
      rx_event <= next_rx_event;
      tx_request <= next_tx_request;
    end
  end
endmodule

/* File: design/tw_unit.sv */
// two-wire bus unit: pins, condition detection, master engine
// Functional notes
// - bus idle only when both lines high
// - each byte is eight bits plus acknowledge
// - bytes go out MSB first, unlimited count
// - receiver may hold clock low; transmitter waits
// - start and stop are data edges, clock high
// - busy after start, free after stop
// - first byte is address plus direction bit
// - master ends with stop or repeated start
// - data changes only while clock is low
// - master clocks acknowledge; transmitter releases data
// - receiver pulls data low to acknowledge
// - unmatched slave stays released; master then stops
// - receiving master leaves last byte unacknowledged
// - transmitting slave releases data after no-acknowledge
// - master starts only on an idle bus
// - released-high but sensed-low means arbitration lost
// - arbitration runs through address and data bits
// - master and slave run independently together
// - standard and fast rate by divider value
// - master event on completion or abort
// - slave event on received or requested data
// - bus period is 2*(divider+1)*(6+4) clocks
// - loop flag joins master and slave internally
`timescale 1ns/100ps
module tw_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic internal_loop_flag,
  input wire logic [7:0] scl_divider_value,
  input wire logic [7:0] master_target_address_reg,
  input wire logic m_cmd_valid,
  output logic m_cmd_ready,
  input wire logic m_cmd_start,
  input wire logic m_cmd_stop,
  input wire logic m_cmd_ack,
  input wire logic [7:0] m_tx_data,
  output logic [7:0] m_rx_data,
  output logic m_done,
  output logic m_error,
  output logic m_arb_lost,
  output logic bus_busy,
  input wire logic s_enable,
  input wire logic [6:0] s_own_address,
  input wire logic [7:0] s_tx_data,
  input wire logic s_tx_valid,
  output logic s_tx_ready,
  output logic [7:0] s_rx_data,
  output logic s_rx_event,
  output logic s_tx_request
);
  // ==========================================
  // line sensing
  logic [1:0] pin_sync;
  logic ms, md, ms_q, md_q, next_ms_q, next_md_q, next_busy;
  logic start_det, stop_det, scl_rise, scl_fall, bus_idle;
  logic m_scl_low, m_sda_low, s_scl_low, s_sda_low;

  tw_sync u_sync (
    .clk(clk),
    .rst(rst),
    .din({scl_i, sda_i}),
    .dout(pin_sync)
  );

  assign ms = internal_loop_flag ? !(m_scl_low || s_scl_low) : pin_sync[1];
  assign md = internal_loop_flag ? !(m_sda_low || s_sda_low) : pin_sync[0];
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = !internal_loop_flag && (m_scl_low || s_scl_low);
  assign sda_oe = !internal_loop_flag && (m_sda_low || s_sda_low);

  // conditions are data edges under a high clock
  assign start_det = ms && ms_q && md_q && !md;
  assign stop_det = ms && ms_q && !md_q && md;
  assign scl_rise = ms && !ms_q;
  assign scl_fall = !ms && ms_q;
  // both lines high and no open transfer
  assign bus_idle = !bus_busy && ms && md;

  always_comb begin
    next_ms_q = ms;
    next_md_q = md;
    next_busy = bus_busy;
    if (start_det) begin
      next_busy = 1'b1;
    end else if (stop_det) begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_q <= 1'b1;
      md_q <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      ms_q <= next_ms_q;
      md_q <= next_md_q;
      bus_busy <= next_busy;
    end
  end

  // ==========================================
  // master engine
  tw_pkg::tw_mstate_type st, next_st;
  logic [7:0] pre, next_pre, sh, next_sh, txd, next_txd, next_rxd;
  logic [4:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic hi, next_hi, addr_ph, next_addr_ph, rd, next_rd, stp, next_stp;
  logic ack, next_ack, next_scl_low, next_sda_low, next_done, next_err, next_arb;
  logic tick, lo_mid, lo_end, hi_end, tx_bit, acc;

  assign tick = pre == scl_divider_value;
  assign lo_mid = tick && !hi && cnt == tw_pkg::low_mid;
  assign lo_end = tick && !hi && cnt == tw_pkg::low_last;
  assign hi_end = tick && hi && ms && cnt == tw_pkg::high_last;
  // every address bit and every written data bit
  assign tx_bit = (addr_ph || !rd) && bitn < tw_pkg::ack_bit;
  // a new transfer only on an idle bus
  assign m_cmd_ready = (st == tw_pkg::m_idle && bus_idle) || st == tw_pkg::m_wait;
  assign acc = m_cmd_valid && m_cmd_ready;

  always_comb begin
    next_st = st;
    next_pre = tick ? 8'h00 : pre + 8'h01;
    next_cnt = cnt;
    next_hi = hi;
    next_bitn = bitn;
    next_sh = sh;
    next_scl_low = m_scl_low;
    next_sda_low = m_sda_low;
    next_addr_ph = addr_ph;
    next_rd = rd;
    next_stp = stp;
    next_ack = ack;
    next_txd = txd;
    next_rxd = m_rx_data;
    next_done = 1'b0;
    next_err = m_error;
    next_arb = m_arb_lost;
    // high phase counts only while clock is sensed high
    if (hi && !ms) begin
      next_cnt = 5'h00;
    end else if (tick) begin
      next_cnt = cnt + 5'h01;
    end
    if (lo_end) begin
      next_scl_low = 1'b0;
      next_hi = 1'b1;
      next_cnt = 5'h00;
    end
    if (hi_end) begin
      next_scl_low = 1'b1;
      next_hi = 1'b0;
      next_cnt = 5'h00;
    end
    if (acc) begin
      next_stp = m_cmd_stop;
      next_ack = m_cmd_ack;
      next_txd = m_tx_data;
      next_err = 1'b0;
      next_arb = 1'b0;
    end
    case (st)
      tw_pkg::m_idle: begin
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
        next_hi = 1'b1;
        next_cnt = 5'h00;
        if (acc) begin
          // a command without start has no bus to use
          next_err = !m_cmd_start;
          if (m_cmd_start) begin
            next_st = tw_pkg::m_start;
            next_sda_low = 1'b1;
            next_rd = master_target_address_reg[0];
          end else begin
            next_done = 1'b1;
          end
        end
      end
      tw_pkg::m_start: begin
        if (hi_end) begin
          next_st = tw_pkg::m_bits;
          next_addr_ph = 1'b1;
          next_bitn = 4'h0;
          next_sh = master_target_address_reg;
        end
      end
      tw_pkg::m_bits: begin
        // data moves at mid low phase
        if (lo_mid) begin
          if (bitn < tw_pkg::ack_bit) begin
            next_sda_low = tx_bit && !sh[7];
          end else begin
            // release unless acking a read byte
            next_sda_low = !addr_ph && rd && ack;
          end
        end
        if (hi && ms && tx_bit && !m_sda_low && !md) begin
          next_st = tw_pkg::m_idle;
          next_arb = 1'b1;
          next_done = 1'b1;
          next_sda_low = 1'b0;
          next_scl_low = 1'b0;
        end else if (hi_end) begin
          // eight data bits then the acknowledge
          if (bitn < tw_pkg::ack_bit) begin
            next_sh = {sh[6:0], md};
            next_bitn = bitn + 4'h1;
          end else if (md && (addr_ph || !rd)) begin
            next_err = 1'b1;
            next_st = tw_pkg::m_stop;
          end else if (addr_ph) begin
            next_addr_ph = 1'b0;
            next_bitn = 4'h0;
            next_sh = txd;
          end else begin
            next_bitn = 4'h0;
            if (rd) begin
              next_rxd = sh;
            end
            if (stp) begin
              next_st = tw_pkg::m_stop;
            end else begin
              next_st = tw_pkg::m_wait;
              next_done = 1'b1;
            end
          end
        end
      end
      tw_pkg::m_wait: begin
        // clock held low keeps the bus ours between commands
        next_cnt = 5'h00;
        next_hi = 1'b0;
        next_scl_low = 1'b1;
        if (acc) begin
          if (m_cmd_start) begin
            next_st = tw_pkg::m_rstart;
            next_rd = master_target_address_reg[0];
          end else begin
            next_st = tw_pkg::m_bits;
            next_sh = m_tx_data;
            next_bitn = 4'h0;
          end
        end
      end
      tw_pkg::m_rstart: begin
        // release data, then start again under a high clock
        if (lo_mid) begin
          next_sda_low = 1'b0;
        end
        if (hi_end) begin
          next_st = tw_pkg::m_start;
          next_sda_low = 1'b1;
          next_scl_low = 1'b0;
          next_hi = 1'b1;
        end
      end
      tw_pkg::m_stop: begin
        // data rises while clock is high
        if (lo_mid) begin
          next_sda_low = 1'b1;
        end
        if (hi_end) begin
          next_st = tw_pkg::m_idle;
          next_sda_low = 1'b0;
          next_scl_low = 1'b0;
          next_hi = 1'b1;
          next_done = 1'b1;
        end
      end
      default: begin
        next_st = tw_pkg::m_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= tw_pkg::m_idle;
      pre <= tw_pkg::byte_reset;
      cnt <= 5'h00;
      hi <= 1'b1;
      bitn <= 4'h0;
      sh <= tw_pkg::byte_reset;
      m_scl_low <= 1'b0;
      m_sda_low <= 1'b0;
      addr_ph <= 1'b0;
      rd <= 1'b0;
      stp <= 1'b0;
      ack <= 1'b0;
      txd <= tw_pkg::byte_reset;
      m_rx_data <= tw_pkg::byte_reset;
      m_done <= 1'b0;
      m_error <= 1'b0;
      m_arb_lost <= 1'b0;
    end else begin
      st <= next_st;
      pre <= next_pre;
      cnt <= next_cnt;
      hi <= next_hi;
      bitn <= next_bitn;
      sh <= next_sh;
      m_scl_low <= next_scl_low;
      m_sda_low <= next_sda_low;
      addr_ph <= next_addr_ph;
      rd <= next_rd;
      stp <= next_stp;
      ack <= next_ack;
      txd <= next_txd;
      m_rx_data <= next_rxd;
      m_done <= next_done;
      m_error <= next_err;
      m_arb_lost <= next_arb;
    end
  end

  // ==========================================
  // slave function
  // separate engine on the same sensed lines
  tw_slave u_slave (
    .clk(clk),
    .rst(rst),
    .sda(md),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .enable(s_enable),
    .own_address(s_own_address),
    .tx_data(s_tx_data),
    .tx_valid(s_tx_valid),
    .tx_ready(s_tx_ready),
    .scl_low(s_scl_low),
    .sda_low(s_sda_low),
    .rx_data(s_rx_data),
    .rx_event(s_rx_event),
    .tx_request(s_tx_request)
  );

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_busy_on_start: assert property (start_det |=> bus_busy)
    else $error("start seen but bus not busy");
  a_free_on_stop: assert property (stop_det |=> !bus_busy)
    else $error("stop seen but bus still busy");
  a_start_when_idle: assert property ($past(st) == tw_pkg::m_idle && st == tw_pkg::m_start |-> $past(bus_idle))
    else $error("master started on a busy bus");
  a_data_stable_high: assert property (st == tw_pkg::m_bits && hi && $past(hi) |-> $stable(m_sda_low))
    else $error("master data moved while clock high");
  a_arb_release: assert property ($rose(m_arb_lost) |-> st == tw_pkg::m_idle && !m_sda_low && !m_scl_low)
    else $error("lost arbitration but still driving");
  a_ack_release: assert property (st == tw_pkg::m_bits && bitn == tw_pkg::ack_bit && hi && (addr_ph || !rd) |-> !m_sda_low)
    else $error("transmitting master held data in acknowledge");
  a_stretch_hold: assert property (st == tw_pkg::m_bits && hi && !ms |=> cnt == 5'h00 && m_scl_low == 1'b0)
    else $error("master ran high phase while clock held low");
  a_loop_pins_free: assert property (internal_loop_flag |-> !scl_oe && !sda_oe)
    else $error("pins driven in loop mode");
  a_done_pulse: assert property (m_done |=> !m_done)
    else $error("done longer than one cycle");
  a_nack_stops: assert property (st == tw_pkg::m_bits && hi_end && bitn == tw_pkg::ack_bit && md && addr_ph |=> st == tw_pkg::m_stop && m_error)
    else $error("address not acknowledged but no stop");
endmodule

/* File: tb/tw_bus_model.sv */
// external bus device: addressed slave, clock stretcher and competing master
`timescale 1ns/100ps
module tw_bus_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic [6:0] addr,
  input wire logic [7:0] rd_byte,
  input wire logic [7:0] stretch,
  input wire logic jam,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] got_byte,
  output logic last_ack
);
  logic ps, pd, act, sel, rw, first, send, jon, dp;
  logic [3:0] bn;
  logic [7:0] sh, txs, st;
  // competing master holds data low from its start
  assign sda_pull = dp | jon;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {ps, pd, last_ack} <= 3'h7;
      {act, sel, rw, first, send, jon, dp, scl_pull} <= 8'h00;
      {bn, sh, txs, st, got_byte} <= 36'h0_0000_0000;
    end else begin
      ps <= scl;
      pd <= sda;
      if (st != 8'h00) st <= st - 8'h01;
      else scl_pull <= 1'b0;
      if (!jam) jon <= 1'b0;
      if (scl && ps && pd && !sda) begin
        {act, first, sel, send, dp} <= 5'h18;
        // the clock fall that closes the start wraps the count to zero
        bn <= 4'hF;
        jon <= jam;
      end else if (scl && ps && !pd && sda) begin
        act <= 1'b0;
      end else if (act && scl && !ps) begin
        if (bn < 4'h8) sh <= {sh[6:0], sda};
        else last_ack <= sda;
      end else if (act && !scl && ps) begin
        bn <= bn + 4'h1;
        // msb first, change while clock low
        if (bn < 4'h7 && send) dp <= !txs[3'(4'h6 - bn)];
        if (bn == 4'h7) begin
          if (first) begin
            sel <= sh[7:1] == addr;
            rw <= sh[0];
            dp <= sh[7:1] == addr;
          end else if (sel && !rw) begin
            got_byte <= sh;
            dp <= 1'b1;
          end else begin
            dp <= 1'b0;
          end
        end
        if (bn == 4'h8) begin
          bn <= 4'h0;
          {first, dp, send} <= 3'h0;
          if (sel && rw && (first || !last_ack)) begin
            send <= 1'b1;
            txs <= first ? rd_byte : ~txs;
            dp <= first ? !rd_byte[7] : txs[7];
          end
          // hold clock low while not ready
          if (sel && stretch != 8'h00) begin
            scl_pull <= 1'b1;
            st <= stretch;
          end
        end
      end
    end
  end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the two-wire bus unit
`timescale 1ns/100ps
module tb;
  localparam logic [6:0] dev_adr = 7'h2B;
  localparam int lim = 40000;
  logic clk = 0, rst = 1, loop = 0, cv = 0, cs = 0, cp = 0, ca = 0, sen = 0, stv = 0, jam = 0;
  logic [7:0] div = 8'h00, tgt = 8'h00, mtx = 8'h00, stx = 8'h00, rdb = 8'h00, stretch = 8'h00;
  logic [6:0] sadr = 7'h00;
  logic scl_oe, sda_oe, mpc, mpd, scl_w, sda_w, ready, done, m_err, arb, busy, s_tx_rdy, s_rx_ev, s_req, mack;
  logic so_c, so_d;
  logic [7:0] m_rx, s_rx, got;
  logic sc_d = 1, seen_busy = 0, rx_seen = 0, rq_seen = 0, clr_seen = 0;
  int err_total = 0, cmp_count = 0, per = 0, cnt = 0;
  // open drain wires with pull-ups
  assign scl_w = ~(scl_oe | mpc);
  assign sda_w = ~(sda_oe | mpd);
  tw_unit uut (.clk(clk), .rst(rst), .scl_i(scl_w), .scl_o(so_c), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(so_d),
    .sda_oe(sda_oe), .internal_loop_flag(loop), .scl_divider_value(div), .master_target_address_reg(tgt),
    .m_cmd_valid(cv), .m_cmd_ready(ready), .m_cmd_start(cs), .m_cmd_stop(cp), .m_cmd_ack(ca),
    .m_tx_data(mtx), .m_rx_data(m_rx), .m_done(done), .m_error(m_err), .m_arb_lost(arb), .bus_busy(busy),
    .s_enable(sen), .s_own_address(sadr), .s_tx_data(stx), .s_tx_valid(stv), .s_tx_ready(s_tx_rdy),
    .s_rx_data(s_rx), .s_rx_event(s_rx_ev), .s_tx_request(s_req));
  tw_bus_model bm (.clk(clk), .rst(rst), .scl(scl_w), .sda(sda_w), .addr(dev_adr), .rd_byte(rdb),
    .stretch(stretch), .jam(jam), .scl_pull(mpc), .sda_pull(mpd), .got_byte(got), .last_ack(mack));
  initial begin
    forever #2 clk = ~clk;
  end
  // clocks between clock-line rises, and sticky event flags
  always @(posedge clk) begin
    sc_d <= scl_w;
    cnt <= cnt + 1;
    if (scl_w && !sc_d) begin
      per <= cnt;
      cnt <= 1;
    end
    if (clr_seen) begin
      {seen_busy, rx_seen, rq_seen} <= 3'h0;
    end else begin
      if (busy === 1'b1) seen_busy <= 1'b1;
      if (s_rx_ev === 1'b1) rx_seen <= 1'b1;
      // a request must come with the clock already held for the byte
      if (s_req === 1'b1 && s_tx_rdy === 1'b1) rq_seen <= 1'b1;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one master command, held until taken, then wait for its done pulse
  task automatic cmd(input logic st, input logic sp, input logic ak, input logic [7:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    {cs, cp, ca, tgt, mtx, cv} = {st, sp, ak, ad, dt, 1'b1};
    while (ready !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 cv = 0;
    while (done !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 if (n >= lim) begin
      err_total++;
      $display("mismatch at %0t: command never finished", $time);
      tally_and_finish;
    end
  endtask
  task automatic idle_wait;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("mismatch at %0t: bus stays busy", $time);
      tally_and_finish;
    end
  endtask
  // sticky flags are cleared through the flag process only
  task automatic clear_seen;
    clr_seen = 1;
    @(posedge clk);
    #1 clr_seen = 0;
  endtask
  task automatic t_write;
    div = tw_pkg::fast_rate_divider;
    clear_seen;
    cmd(1, 1, 0, {dev_adr, 1'b0}, 8'hA5);
    idle_wait;
    check(got, 8'hA5);
    check({7'h00, m_err}, 8'h01 ^ 8'h01);
    check({7'h00, seen_busy}, 8'h01);
    check({7'h00, busy}, 8'h00);
    check({6'h00, so_c, so_d}, 8'h00);
    check({7'h00, per >= 20 * (div + 1) && per <= 20 * (div + 1) + 4}, 8'h01);
    $display("write test ended");
  endtask
  task automatic t_refuse;
    div = 8'h00;
    clear_seen;
    cmd(0, 0, 0, {dev_adr, 1'b0}, 8'h33);
    check({7'h00, m_err}, 8'h01);
    check({7'h00, seen_busy}, 8'h00);
    $display("refuse test ended");
  endtask
  task automatic t_read;
    stretch = 8'h1E;
    rdb = 8'h1C;
    cmd(1, 0, 1, {dev_adr, 1'b1}, 8'h00);
    check(m_rx, 8'h1C);
    check({7'h00, mack}, 8'h00);
    cmd(0, 1, 0, {dev_adr, 1'b1}, 8'h00);
    check(m_rx, 8'hE3);
    check({7'h00, mack}, 8'h01);
    idle_wait;
    check({7'h00, m_err}, 8'h00);
    stretch = 8'h00;
    $display("read test ended");
  endtask
  task automatic t_nack;
    cmd(1, 1, 0, {7'h55, 1'b0}, 8'h0F);
    check({7'h00, m_err}, 8'h01);
    idle_wait;
    check({7'h00, busy}, 8'h00);
    $display("nack test ended");
  endtask
  task automatic t_arb;
    jam = 1;
    cmd(1, 1, 0, {7'h50, 1'b0}, 8'h00);
    check({7'h00, arb}, 8'h01);
    check({6'h00, ready, busy}, 8'h01);
    jam = 0;
    idle_wait;
    check({7'h00, busy}, 8'h00);
    $display("arbitration test ended");
  endtask
  task automatic t_loop;
    {loop, sen, sadr} = {2'h3, 7'h19};
    clear_seen;
    cmd(1, 1, 0, {7'h19, 1'b0}, 8'h6D);
    idle_wait;
    check(s_rx, 8'h6D);
    check({6'h00, rx_seen, m_err}, 8'h02);
    check(got, 8'hA5);
    {stx, stv} = {8'h96, 1'b1};
    cmd(1, 1, 0, {7'h19, 1'b1}, 8'h00);
    idle_wait;
    stv = 0;
    check(m_rx, 8'h96);
    check({7'h00, rq_seen}, 8'h01);
    $display("loopback test ended");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 0;
    t_write;
    t_refuse;
    t_read;
    t_nack;
    t_arb;
    t_loop;
    tally_and_finish;
  end
endmodule
